// file: include/hs_pkg.sv
// shared constants and types of the homing sequencer
package hs_pkg;

  // supported homing methods
  localparam logic [7:0] METHOD_FIRST = 8'h16;
  localparam logic [7:0] METHOD_LAST = 8'h1A;
  localparam logic [2:0] IDX_M22 = 3'h0;
  localparam logic [2:0] IDX_M23 = 3'h1;
  localparam logic [2:0] IDX_M24 = 3'h2;
  localparam logic [2:0] IDX_M25 = 3'h3;
  localparam logic [2:0] IDX_M26 = 3'h4;

  // bit positions of the sensor inputs inside the synchroniser
  localparam int IN_HOME = 0;
  localparam int IN_PLIM = 1;
  localparam int IN_NLIM = 2;
  localparam int IN_COUNT = 3;

  // widths and reset values
  localparam int POS_W = 32;
  localparam logic [1:0] STEP_FIRST = 2'h0;
  localparam logic [1:0] STEP_AFTER_LIMIT = 2'h1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MOVE = 2'b01,
    ST_STOP = 2'b10
  } hs_state_t;

  // which path through a method the axis is on
  typedef enum logic [1:0] {
    BR_ACT = 2'b00,
    BR_INACT = 2'b01,
    BR_LIM = 2'b10
  } hs_branch_t;

  typedef enum logic [1:0] {
    CAUSE_NONE = 2'b00,
    CAUSE_LIMIT = 2'b01,
    CAUSE_PL_TWICE = 2'b10,
    CAUSE_METHOD = 2'b11
  } hs_cause_t;

  // command to the motion profiler
  typedef struct packed {
    logic run;
    logic dir_pos;
    logic fast;
  } hs_motion_t;

  localparam hs_motion_t MOTION_RESET = 3'h0;

  // one segment: direction, speed, ending edge, final segment
  typedef struct packed {
    logic dir_pos;
    logic fast;
    logic edge_on;
    logic last;
  } hs_seg_t;

endpackage

// file: core/hs_sensor_sync.sv
// three-stage synchroniser and edge detector for the sensor pins
module hs_sensor_sync
  import hs_pkg::*;
#(
  parameter int W = IN_COUNT
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // raw pins
  input wire logic [W-1:0] pin,
  // filtered levels and one-cycle edges
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        level[i] <= 1'b0;
        rise[i] <= 1'b0;
        fall[i] <= 1'b0;
      end else if (s2[i] == s3[i] && s3[i] != level[i]) begin
        level[i] <= s3[i];
        rise[i] <= s3[i];
        fall[i] <= ~s3[i];
      end else begin
        rise[i] <= 1'b0;
        fall[i] <= 1'b0;
      end
    end
  end

endmodule // hs_sensor_sync

// file: core/hs_homing.sv
// homing sequencer for methods 22 to 26 of a servo axis
// Function
// - 22 inactive: neg fast, back fast, neg slow
// - 22 active: pos fast off, neg slow on
// - 22: any limit active aborts with alarm
// - 23 limit path: limit, off, back, slow off
// - 23 switch first: on, neg fast off origin
// - 23 active: off, back fast, neg slow off
// - 23-26: first positive limit reverses, second aborts
// - 24 limit path: limit, off, pos slow on
// - 24 switch first: on, back, pos slow on
// - 24 active: neg fast off, pos slow on
// - 25 limit path: limit, on, back, slow on
// - 25 switch first: pos fast off, slow on
// - 25 active: pos fast off, neg slow on
// - 26 limit path: limit, on, pos slow off
// - 26 other: off, back fast, pos slow off
// - overshoot past narrow switch region tolerated
// - stop to standstill; origin where stop ends
module hs_homing
  import hs_pkg::*;
#(
  parameter int PW = POS_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // sensors
  input wire logic home_switch,
  input wire logic positive_limit,
  input wire logic negative_limit,
  // homing control
  input wire logic start,
  input wire logic cancel,
  input wire logic [7:0] method,
  // motion profiler
  output hs_motion_t motion,
  input wire logic at_standstill,
  input wire logic [PW-1:0] axis_position,
  // status
  output logic busy,
  output logic done,
  output logic alarm,
  output hs_cause_t alarm_cause,
  output logic origin_strobe,
  output logic [PW-1:0] origin_position
);

  logic [IN_COUNT-1:0] sens_lvl;
  logic [IN_COUNT-1:0] sens_rise;
  logic [IN_COUNT-1:0] sens_fall;

  hs_state_t state;
  hs_branch_t branch;
  logic [1:0] step;
  logic [2:0] midx;
  logic pl_seen;
  hs_seg_t cur_seg;
  hs_seg_t next_seg;
  hs_seg_t start_seg;
  hs_branch_t start_branch;
  logic [2:0] start_midx;
  logic method_ok;
  logic seg_end;
  logic lim_abort;
  logic pl_reverse;
  logic [1:0] next_step;

  hs_sensor_sync #(.W(IN_COUNT)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .pin({negative_limit, positive_limit, home_switch}),
    .level(sens_lvl),
    .rise(sens_rise),
    .fall(sens_fall)
  );

  function automatic hs_seg_t mk(input logic dir_pos, input logic fast,
                                 input logic edge_on, input logic last);
    mk = '{dir_pos: dir_pos, fast: fast, edge_on: edge_on, last: last};
  endfunction

  // segment table; edge_on=1 ends on off-to-on, 0 on on-to-off
  function automatic hs_seg_t seg_of(input logic [2:0] m,
                                     input hs_branch_t br,
                                     input logic [1:0] st);
    hs_seg_t s;
    s = mk(1'b0, 1'b0, 1'b0, 1'b1);
    // the limit path starts with the positive run that met the limit
    if (br == BR_LIM && st == STEP_FIRST) begin
      s = mk(1'b1, 1'b1, 1'b1, 1'b0);
    end else begin
      unique case (m)
        IDX_M22: begin
          if (br == BR_ACT) begin
            unique case (st)
              2'h0: s = mk(1'b1, 1'b1, 1'b0, 1'b0);
              default: s = mk(1'b0, 1'b0, 1'b1, 1'b1);
            endcase
          end else begin
            unique case (st)
              2'h0: s = mk(1'b0, 1'b1, 1'b1, 1'b0);
              2'h1: s = mk(1'b1, 1'b1, 1'b0, 1'b0);
              default: s = mk(1'b0, 1'b0, 1'b1, 1'b1);
            endcase
          end
        end
        IDX_M23: begin
          unique case ({br, st})
            {BR_ACT, 2'h0}: s = mk(1'b0, 1'b1, 1'b0, 1'b0);
            {BR_ACT, 2'h1}: s = mk(1'b1, 1'b1, 1'b1, 1'b0);
            {BR_ACT, 2'h2}: s = mk(1'b0, 1'b0, 1'b0, 1'b1);
            {BR_INACT, 2'h0}: s = mk(1'b1, 1'b1, 1'b1, 1'b0);
            {BR_INACT, 2'h1}: s = mk(1'b0, 1'b1, 1'b0, 1'b1);
            {BR_LIM, 2'h1}: s = mk(1'b0, 1'b1, 1'b0, 1'b0);
            {BR_LIM, 2'h2}: s = mk(1'b1, 1'b1, 1'b1, 1'b0);
            default: s = mk(1'b0, 1'b0, 1'b0, 1'b1);
          endcase
        end
        IDX_M24: begin
          unique case ({br, st})
            {BR_ACT, 2'h0}: s = mk(1'b0, 1'b1, 1'b0, 1'b0);
            {BR_ACT, 2'h1}: s = mk(1'b1, 1'b0, 1'b1, 1'b1);
            {BR_INACT, 2'h0}: s = mk(1'b1, 1'b1, 1'b1, 1'b0);
            {BR_INACT, 2'h1}: s = mk(1'b0, 1'b1, 1'b0, 1'b0);
            {BR_LIM, 2'h1}: s = mk(1'b0, 1'b1, 1'b0, 1'b0);
            default: s = mk(1'b1, 1'b0, 1'b1, 1'b1);
          endcase
        end
        IDX_M25: begin
          unique case ({br, st})
            {BR_ACT, 2'h0}: s = mk(1'b1, 1'b1, 1'b0, 1'b0);
            {BR_INACT, 2'h0}: s = mk(1'b1, 1'b1, 1'b0, 1'b0);
            {BR_LIM, 2'h1}: s = mk(1'b0, 1'b1, 1'b1, 1'b0);
            {BR_LIM, 2'h2}: s = mk(1'b1, 1'b1, 1'b0, 1'b0);
            default: s = mk(1'b0, 1'b0, 1'b1, 1'b1);
          endcase
        end
        IDX_M26: begin
          unique case ({br, st})
            {BR_LIM, 2'h1}: s = mk(1'b0, 1'b1, 1'b1, 1'b0);
            {BR_LIM, 2'h2}: s = mk(1'b1, 1'b0, 1'b0, 1'b1);
            {BR_ACT, 2'h0}, {BR_INACT, 2'h0}:
              s = mk(1'b1, 1'b1, 1'b0, 1'b0);
            {BR_ACT, 2'h1}, {BR_INACT, 2'h1}:
              s = mk(1'b0, 1'b1, 1'b1, 1'b0);
            default: s = mk(1'b1, 1'b0, 1'b0, 1'b1);
          endcase
        end
        default: s = mk(1'b0, 1'b0, 1'b0, 1'b1);
      endcase
    end
    seg_of = s;
  endfunction

  // start decode: method range and starting branch from switch level
  always_comb begin
    method_ok = method >= METHOD_FIRST && method <= METHOD_LAST;
    start_midx = 3'(method - METHOD_FIRST);
    start_branch = sens_lvl[IN_HOME] ? BR_ACT : BR_INACT;
    start_seg = seg_of(start_midx, start_branch, STEP_FIRST);
  end

  always_comb begin
    cur_seg = seg_of(midx, branch, step);
    next_step = 2'(step + 2'h1);
    next_seg = seg_of(midx, branch, next_step);
    // edges only count while moving; the reverse run ends on the first
    // edge into the region, so an overshoot beyond it is harmless
    seg_end = cur_seg.edge_on ? sens_rise[IN_HOME]
                              : sens_fall[IN_HOME];
    lim_abort = sens_lvl[IN_NLIM] ||
                (midx == IDX_M22 && sens_lvl[IN_PLIM]);
    pl_reverse = midx != IDX_M22 && cur_seg.dir_pos &&
                 sens_lvl[IN_PLIM];
  end

  // sequencer state and path through the method
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      branch <= BR_ACT;
      step <= STEP_FIRST;
      midx <= IDX_M22;
      pl_seen <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start && method_ok) begin
            state <= ST_MOVE;
            branch <= start_branch;
            step <= STEP_FIRST;
            midx <= start_midx;
            pl_seen <= 1'b0;
          end
        end
        ST_MOVE: begin
          if (cancel || lim_abort) begin
            state <= ST_IDLE;
          end else if (pl_reverse) begin
            if (pl_seen) begin
              state <= ST_IDLE;
            end else begin
              // stop, then resume on the negative run of the limit path
              pl_seen <= 1'b1;
              branch <= BR_LIM;
              step <= STEP_FIRST;
              state <= ST_STOP;
            end
          end else if (seg_end) begin
            state <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (cancel) begin
            state <= ST_IDLE;
          end else if (at_standstill) begin
            if (cur_seg.last) begin
              state <= ST_IDLE;
            end else begin
              step <= next_step;
              state <= ST_MOVE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // profiler command: run drops on every segment end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      motion <= MOTION_RESET;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start && method_ok) begin
            motion <= '{run: 1'b1, dir_pos: start_seg.dir_pos,
                        fast: start_seg.fast};
          end
        end
        ST_MOVE: begin
          if (cancel || lim_abort || pl_reverse || seg_end) begin
            motion.run <= 1'b0;
          end
        end
        ST_STOP: begin
          if (!cancel && at_standstill && !cur_seg.last) begin
            motion <= '{run: 1'b1, dir_pos: next_seg.dir_pos,
                        fast: next_seg.fast};
          end
        end
        default: motion <= MOTION_RESET;
      endcase
    end
  end

  // origin is where the final deceleration ends, not the edge
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      origin_strobe <= 1'b0;
      origin_position <= '0;
    end else begin
      origin_strobe <= 1'b0;
      if (state == ST_STOP && !cancel && at_standstill && cur_seg.last) begin
        origin_strobe <= 1'b1;
        origin_position <= axis_position;
      end
    end
  end

  // status flags; a new start clears done, and clears the alarm only with a valid method
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      done <= 1'b0;
      alarm <= 1'b0;
      alarm_cause <= CAUSE_NONE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            done <= 1'b0;
            busy <= method_ok;
            alarm <= !method_ok;
            alarm_cause <= method_ok ? CAUSE_NONE : CAUSE_METHOD;
          end
        end
        ST_MOVE: begin
          if (cancel) begin
            busy <= 1'b0;
          end else if (lim_abort) begin
            busy <= 1'b0;
            alarm <= 1'b1;
            alarm_cause <= CAUSE_LIMIT;
          end else if (pl_reverse && pl_seen) begin
            busy <= 1'b0;
            alarm <= 1'b1;
            alarm_cause <= CAUSE_PL_TWICE;
          end
        end
        ST_STOP: begin
          if (cancel) begin
            busy <= 1'b0;
          end else if (at_standstill && cur_seg.last) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
        default: busy <= 1'b0;
      endcase
    end
  end

endmodule // hs_homing

// file: sim/hs_homing_monitor.sv
// port assertions for the homing sequencer
module hs_homing_monitor
  import hs_pkg::*;
#(
  parameter int PW = POS_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // sensors and control
  input wire logic home_switch,
  input wire logic positive_limit,
  input wire logic negative_limit,
  input wire logic start,
  input wire logic cancel,
  input wire logic [7:0] method,
  // profiler
  input wire hs_motion_t motion,
  input wire logic at_standstill,
  input wire logic [PW-1:0] axis_position,
  // status
  input wire logic busy,
  input wire logic done,
  input wire logic alarm,
  input wire hs_cause_t alarm_cause,
  input wire logic origin_strobe,
  input wire logic [PW-1:0] origin_position
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_go;
    start && !busy && method >= METHOD_FIRST && method <= METHOD_LAST
      |=> busy && motion.run;
  endproperty
  a_go: assert property (p_go) else $error("start not taken");
  property p_bad;
    start && !busy && (method < METHOD_FIRST || method > METHOD_LAST)
      |=> alarm && alarm_cause == CAUSE_METHOD && !busy;
  endproperty
  a_bad: assert property (p_bad) else $error("bad method");
  // sync latency is four cycles and busy drops one later, so five is the worst case and six leaves a spare
  property p_nl;
    busy && motion.run && negative_limit |-> ##[1:6] !busy;
  endproperty
  a_nl: assert property (p_nl) else $error("no limit abort");
  property p_abort;
    $rose(alarm) |-> !busy && !motion.run && alarm_cause != CAUSE_NONE;
  endproperty
  a_abort: assert property (p_abort) else $error("bad abort");
  property p_sticky;
    alarm && !start |=> alarm;
  endproperty
  a_sticky: assert property (p_sticky) else $error("alarm lost");
  property p_done;
    origin_strobe |-> done && !busy;
  endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_hold;
    busy && !motion.run && !at_standstill |=> !motion.run;
  endproperty
  a_hold: assert property (p_hold) else $error("ran early");
  property p_next;
    busy && !motion.run && at_standstill |=> motion.run || !busy;
  endproperty
  a_next: assert property (p_next) else $error("stuck stop");
  // the latch edge is the first standstill sample, one cycle back
  property p_origin;
    origin_strobe |-> origin_position == $past(axis_position) &&
      $past(at_standstill) && !$past(motion.run);
  endproperty
  a_origin: assert property (p_origin) else $error("bad origin");
  property p_cancel;
    cancel && busy |=> !busy && !motion.run && !origin_strobe;
  endproperty
  a_cancel: assert property (p_cancel) else $error("no cancel");
endmodule // hs_homing_monitor

bind hs_homing hs_homing_monitor #(.PW(PW)) hs_homing_monitor_i (
  .mclk(mclk), .reset(reset), .home_switch(home_switch),
  .positive_limit(positive_limit), .negative_limit(negative_limit),
  .start(start), .cancel(cancel), .method(method), .motion(motion),
  .at_standstill(at_standstill), .axis_position(axis_position),
  .busy(busy), .done(done), .alarm(alarm), .alarm_cause(alarm_cause),
  .origin_strobe(origin_strobe), .origin_position(origin_position)
);

// file: sim/hs_axis_model.sv
// behavioural axis with home switch, travel limits and profiler
module hs_axis_model
  import hs_pkg::*;
(
  // clock
  input wire logic mclk,
  // profiler command and feedback
  input wire hs_motion_t motion,
  output logic at_standstill,
  output logic [31:0] axis_position,
  // sensors, high when on
  output logic home_switch,
  output logic positive_limit,
  output logic negative_limit
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos = 0;
  int hlo = 100;
  int hhi = 140;
  int pl = 400;
  int nl = -400;
  int idle_cnt = 0;
  always @(posedge mclk) begin
    if (motion.run) begin
      pos <= pos + (motion.dir_pos ? 1 : -1) * (motion.fast ? 4 : 1);
      idle_cnt <= 0;
    end else if (idle_cnt < 2) begin
      idle_cnt <= idle_cnt + 1;
    end
  end
  // standstill lags the stop command, as a real ramp-down would
  assign at_standstill = !motion.run && idle_cnt >= 2;
  assign axis_position = 32'(pos);
  assign home_switch = pos >= hlo && pos <= hhi;
  assign positive_limit = pos >= pl;
  assign negative_limit = pos <= nl;
endmodule // hs_axis_model

// file: sim/hs_homing_tb.sv
// self-checking bench of the homing sequencer
module hs_homing_tb
  import hs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0;
  logic reset = 1;
  logic start = 0;
  logic cancel = 0;
  logic [7:0] method = 8'h00;
  hs_motion_t motion;
  logic at_standstill, home_switch, positive_limit, negative_limit;
  logic [31:0] axis_position, origin_position;
  logic busy, done, alarm, origin_strobe;
  hs_cause_t alarm_cause;
  int error_cnt = 0;
  int tests_run = 0;
  int strobe_cnt = 0;

  always @(posedge mclk) begin
    if (origin_strobe === 1'b1) begin
      strobe_cnt <= strobe_cnt + 1;
    end
  end

  hs_homing hs_homing_i (
    .mclk(mclk), .reset(reset), .home_switch(home_switch),
    .positive_limit(positive_limit), .negative_limit(negative_limit),
    .start(start), .cancel(cancel), .method(method), .motion(motion),
    .at_standstill(at_standstill), .axis_position(axis_position),
    .busy(busy), .done(done), .alarm(alarm), .alarm_cause(alarm_cause),
    .origin_strobe(origin_strobe), .origin_position(origin_position)
  );
  hs_axis_model hs_axis_model_i (
    .mclk(mclk), .motion(motion), .at_standstill(at_standstill),
    .axis_position(axis_position), .home_switch(home_switch),
    .positive_limit(positive_limit), .negative_limit(negative_limit)
  );

  initial begin
    forever #10 mclk = ~mclk;
  end

  task automatic conclude;
    $display("tests %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
      error_cnt++;
    end
  endtask

  // six idle cycles let the sensor synchroniser settle first
  task automatic go(input logic [7:0] m, input int p0, input int lo,
                    input int hi);
    hs_axis_model_i.pos = p0;
    hs_axis_model_i.hlo = lo;
    hs_axis_model_i.hhi = hi;
    hs_axis_model_i.pl = 400;
    hs_axis_model_i.nl = -400;
    repeat (6) @(negedge mclk);
    method = m;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
  endtask

  task automatic fin(input string name, input int elo, input int ehi,
                     input hs_cause_t cause);
    int n;
    int s0;
    n = 0;
    s0 = strobe_cnt;
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    // one more cycle lets the strobe counter take the last pulse
    @(negedge mclk);
    chk("busy", 0, busy);
    chk("origin strobes", cause == CAUSE_NONE, strobe_cnt - s0);
    chk("alarm_cause", cause, alarm_cause);
    chk("alarm", cause != CAUSE_NONE, alarm);
    if (cause == CAUSE_NONE) begin
      chk("done", 1, done);
      chk("origin", hs_axis_model_i.pos, origin_position);
      chk("origin window", 1, $signed(origin_position) >= elo &&
          $signed(origin_position) <= ehi);
    end
    $display("test %s finished", name);
  endtask

  task automatic t_pl_twice;
    int n;
    go(8'h19, 200, 100, 140);
    n = 0;
    while (!(motion.run === 1'b1 && motion.dir_pos === 1'b0) && n < 500) begin
      @(negedge mclk);
      n++;
    end
    hs_axis_model_i.pl = 130;
    fin("second limit", 0, 0, CAUSE_PL_TWICE);
  endtask

  task automatic t_cancel;
    go(8'h16, 200, 100, 140);
    repeat (10) @(negedge mclk);
    cancel = 1'b1;
    @(negedge mclk);
    cancel = 1'b0;
    repeat (2) @(negedge mclk);
    chk("busy", 0, busy);
    chk("alarm", 0, alarm);
    chk("done", 0, done);
    $display("test cancel finished");
  endtask

  task automatic t_nl_abort;
    go(8'h16, 200, 100, 140);
    hs_axis_model_i.nl = 150;
    fin("limit abort", 0, 0, CAUSE_LIMIT);
  endtask

  // positive limit is on at once while the axis runs negative
  task automatic t_pl_m22;
    go(8'h16, 200, 100, 140);
    hs_axis_model_i.pl = 150;
    fin("m22 positive limit", 0, 0, CAUSE_LIMIT);
  endtask

  task automatic t_m22_inact;
    go(8'h16, 200, 100, 140);
    fin("m22 inactive", 132, 140, CAUSE_NONE);
  endtask

  task automatic t_m22_act;
    go(8'h16, 120, 100, 140);
    fin("m22 active", 132, 140, CAUSE_NONE);
  endtask

  task automatic t_m23_lim;
    go(8'h17, 200, 100, 140);
    fin("m23 limit", 91, 99, CAUSE_NONE);
  endtask

  task automatic t_m23_neg;
    go(8'h17, 50, 100, 140);
    fin("m23 negative", 60, 99, CAUSE_NONE);
  endtask

  task automatic t_m23_narrow;
    go(8'h17, 105, 100, 110);
    fin("m23 narrow", 91, 99, CAUSE_NONE);
  endtask

  task automatic t_m24_lim;
    go(8'h18, 200, 100, 140);
    fin("m24 limit", 100, 108, CAUSE_NONE);
  endtask

  task automatic t_m24_neg;
    go(8'h18, 50, 100, 140);
    fin("m24 negative", 100, 108, CAUSE_NONE);
  endtask

  task automatic t_m24_act;
    go(8'h18, 120, 100, 140);
    fin("m24 active", 100, 108, CAUSE_NONE);
  endtask

  task automatic t_m25_lim;
    go(8'h19, 200, 100, 140);
    fin("m25 limit", 132, 140, CAUSE_NONE);
  endtask

  task automatic t_m25_neg;
    go(8'h19, 50, 100, 140);
    fin("m25 negative", 132, 140, CAUSE_NONE);
  endtask

  task automatic t_m25_act;
    go(8'h19, 120, 100, 140);
    fin("m25 active", 132, 140, CAUSE_NONE);
  endtask

  task automatic t_m26_lim;
    go(8'h1a, 200, 100, 140);
    fin("m26 limit", 141, 149, CAUSE_NONE);
  endtask

  task automatic t_m26_neg;
    go(8'h1a, 50, 100, 140);
    fin("m26 negative", 141, 149, CAUSE_NONE);
  endtask

  task automatic t_m26_act;
    go(8'h1a, 120, 100, 140);
    fin("m26 active", 141, 149, CAUSE_NONE);
  endtask

  task automatic t_bad_method;
    go(8'h15, 120, 100, 140);
    fin("method low", 0, 0, CAUSE_METHOD);
    go(8'h1b, 120, 100, 140);
    fin("method high", 0, 0, CAUSE_METHOD);
  endtask

  initial begin
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    t_m22_inact();
    t_m22_act();
    t_nl_abort();
    t_pl_m22();
    t_m23_lim();
    t_m23_neg();
    t_m23_narrow();
    t_m24_lim();
    t_m24_neg();
    t_m24_act();
    t_m25_lim();
    t_m25_neg();
    t_m25_act();
    t_m26_lim();
    t_m26_neg();
    t_m26_act();
    t_pl_twice();
    t_bad_method();
    t_cancel();
    conclude();
  end

  // about 20,000 cycles, several times what the scenarios need
  initial begin
    #400_000;
    error_cnt++;
    conclude();
  end
endmodule // hs_homing_tb
